// File: cfg_pkg.sv
// shared types of the configuration port
package cfg_pkg;
  typedef enum logic [1:0] {MODE_STANDBY, MODE_RECEIVE, MODE_TRANSMIT} op_mode_t;
  typedef logic [13:0] cfg_word_t;
endpackage : cfg_pkg

// File: cfg_regs.svh
// register map, field positions and reset values of the configuration port
`ifndef CFG_REGS_SVH
`define CFG_REGS_SVH

`define WORD_W 16
`define DATA_W 14
`define DATA_LSB 2
`define DATA_MSB 15
`define ADDR_MSB 1
`define ADDR_LSB 0
`define NUM_REGS 3

`define ADR_PLL 2'h0
`define ADR_CHAN 2'h1
`define ADR_TEST 2'h2

`define IDX_PLL 0
`define IDX_CHAN 1
`define IDX_TEST 2

`define REG_RESET 14'h0000
`define WORD_RESET 16'h0000

`define CP_POL_BIT 0
`define REF_LO_BIT 1
`define APIN_SEL_BIT 2
`define REF_HI_BIT 3
`define CARRIER_BIT 4
`define PWR_CTL_BIT 5
`define RF_MODE_BIT 6
`define LOW_VOLTAGE_LOCKOUT_EN_BIT 8
`define RSSI_CLIP_BIT 9

`define CHAN_MSB 11
`define CHAN_LSB 0
`define ATEST_MSB 2
`define ATEST_LSB 0
`define DTEST_MSB 5
`define DTEST_LSB 3
`define ATEST_OFF 3'h0

`define SYNC_W 6
`define SYNC_RESET 6'h01
`define S_EN_N 0
`define S_SCLK 1
`define S_SDATA 2
`define S_CHIP 3
`define S_RX 4
`define S_LOWV 5

`endif

// File: host_model.sv
// host-side model: drives the three-wire link and the mode pins
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  output logic ser_en_n,
  output logic ser_data,
  output logic ser_clk,
  output logic chip_en,
  output logic rx_sel,
  output logic supply_low
);
  logic last_bit;
  initial begin
    ser_en_n = 1'b1;
    ser_data = 1'b0;
    ser_clk = 1'b0;
    chip_en = 1'b0;
    rx_sel = 1'b0;
    supply_low = 1'b0;
    last_bit = 1'b0;
  end
  // every task is entered just after a rising core edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // link clock idles low; one bit takes 800 ns
  task automatic shift_bit(input logic b);
    ser_data = b;
    last_bit = b;
    cyc(4);
    ser_clk = 1'b1;
    cyc(4);
    ser_clk = 1'b0;
  endtask
  // optional 4-bit lead-in makes a 20-bit frame
  task automatic send(input logic [3:0] pre, input logic use_pre, input logic [15:0] w);
    ser_en_n = 1'b0;
    cyc(4);
    if (use_pre) begin
      for (int i = 3; i >= 0; i--) shift_bit(pre[i]);
    end
    for (int i = 15; i >= 0; i--) shift_bit(w[i]);
    cyc(4);
    ser_en_n = 1'b1;
    // released data line must not keep its last value
    ser_data = ~last_bit;
    cyc(4);
  endtask
  // clock and data activity while the frame is closed
  task automatic idle_noise(input int n);
    for (int i = 0; i < n; i++) begin
      ser_data = ~ser_data;
      cyc(2);
      ser_clk = 1'b1;
      cyc(2);
      ser_clk = 1'b0;
    end
  endtask
  task automatic set_pins(input logic ce, input logic rx, input logic lv);
    chip_en = ce;
    rx_sel = rx;
    supply_low = lv;
    cyc(8);
  endtask
endmodule // host_model

// File: pin_sync.sv
// two-flop synchroniser bank for asynchronous pins
`timescale 1ns/1ps
`include "cfg_regs.svh"
module pin_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`SYNC_W-1:0] d,
  output logic [`SYNC_W-1:0] q
);
  logic [`SYNC_W-1:0] meta_ff;
  logic [`SYNC_W-1:0] sync_ff;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= `SYNC_RESET;
      sync_ff <= `SYNC_RESET;
    end else begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end

  assign q = sync_ff;
endmodule // pin_sync

// File: serial_shifter.sv
// serial word shifter with edge detection of clock and framing enable
`timescale 1ns/1ps
`include "cfg_regs.svh"
module serial_shifter (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk_s,
  input wire logic sdata_s,
  input wire logic en_n_s,
  output logic [`WORD_W-1:0] word,
  output logic load
);
  logic sclk_prev_ff;
  logic en_prev_ff;
  logic [`WORD_W-1:0] shift_ff;
  logic [`WORD_W-1:0] nxt_shift;
  wire sclk_rise = sclk_s & ~sclk_prev_ff;

  // only the newest sixteen bits survive a long frame
  assign nxt_shift = (sclk_rise && !en_n_s) ? {shift_ff[`WORD_W-2:0], sdata_s} : shift_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_prev_ff <= 1'h0;
      en_prev_ff <= 1'h1;
      shift_ff <= `WORD_RESET;
    end else begin
      sclk_prev_ff <= sclk_s;
      en_prev_ff <= en_n_s;
      shift_ff <= nxt_shift;
    end
  end

  assign word = shift_ff;
  assign load = en_n_s & ~en_prev_ff;
endmodule // serial_shifter

// File: tb_top.sv
// self-checking bench for the three-wire configuration registers
`timescale 1ns/1ps
`include "cfg_regs.svh"
module tb_top;
  logic core_clk;
  logic rst;
  logic ser_en_n, ser_data, ser_clk, chip_en, rx_sel, supply_low;
  logic cp, ref_lo, ref_hi, pin_sel, carrier, pwr_ctl, rf_mode, low_voltage_lockout_en_en, rssi_dis;
  logic [11:0] chan;
  logic [2:0] atest;
  logic [2:0] dtest;
  logic m_sb, m_rx, m_tx, pa_en, rf_on, mod_on, pin_o, pin_oe;
  logic pin_lvl;
  logic [15:0] pll_seen;
  int err_count;
  int checks;
  logic [13:0] pats [3] = '{14'h0355, 14'h007A, 14'h037F};

  // open-drain pin with an external pull-up
  assign pin_lvl = pin_oe ? pin_o : 1'b1;
  assign pll_seen = {6'h00, rssi_dis, low_voltage_lockout_en_en, 1'b0, rf_mode, pwr_ctl, carrier, ref_hi,
                     pin_sel, ref_lo, cp};

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  host_model host (.clk(core_clk), .ser_en_n(ser_en_n), .ser_data(ser_data),
    .ser_clk(ser_clk), .chip_en(chip_en), .rx_sel(rx_sel), .supply_low(supply_low));

  three_wire_config_regs uut (.CORE_CLK(core_clk), .RST(rst), .SER_EN_N(ser_en_n),
    .SER_DATA(ser_data), .SER_CLK(ser_clk), .CHIP_ENABLE_IN(chip_en),
    .RECEIVE_SELECT_IN(rx_sel), .ANALOG_SUPPLY_LOW(supply_low), .ANALOG_PIN_I(pin_lvl),
    .CHARGE_PUMP_POLARITY(cp), .REF_DIVIDE_LOW(ref_lo), .REF_DIVIDE_HIGH(ref_hi),
    .ANALOG_PIN_SELECT(pin_sel), .CARRIER_ONLY_TEST(carrier),
    .POWER_CONTROL_LEVEL(pwr_ctl), .RF_OUTPUT_MODE(rf_mode),
    .LOW_VOLTAGE_LOCKOUT_EN(low_voltage_lockout_en_en), .RSSI_CLIP_DISABLE(rssi_dis),
    .CHANNEL_DIVIDE_WORD(chan), .ANALOG_TEST_SELECT(atest), .DIGITAL_TEST_SELECT(dtest),
    .MODE_STANDBY_OUT(m_sb), .MODE_RECEIVE_OUT(m_rx), .MODE_TRANSMIT_OUT(m_tx),
    .PA_ENABLE_OUT(pa_en), .RF_OUTPUT_ON(rf_on), .MODULATION_ON(mod_on),
    .ANALOG_PIN_O(pin_o), .ANALOG_PIN_OE(pin_oe));

  // ---------------------------------------------
  // checking and closing
  // ---------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    if (err_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // load takes 3 core edges after the frame closes
  task automatic wr(input logic [1:0] adr, input logic [13:0] d);
    host.send(4'h0, 1'b0, {d, adr});
    host.cyc(2);
  endtask

  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    rst = 1'b1;
    err_count = 0;
    checks = 0;
    repeat (20) @(posedge core_clk);
    #1;
    rst = 1'b0;
    host.cyc(8);
    chk("pll", 16'h0000, pll_seen);
    chk("chan", 16'h0000, {4'h0, chan});
    chk("test", 16'h0000, {10'h000, dtest, atest});
    chk("mode", 16'h0004, {13'h0000, m_sb, m_rx, m_tx});
    chk("tx", 16'h0000, {13'h0000, pa_en, rf_on, mod_on});
    chk("pin_oe", 16'h0001, {15'h0000, pin_oe});
    chk("pin", 16'h0000, {15'h0000, pin_lvl});
    // registers load while in standby; reserved bits always zero
    for (int i = 0; i < 3; i++) begin
      wr(`ADR_PLL, pats[i]);
      chk("pll", {6'h00, pats[i][9:8], 1'b0, pats[i][6:0]}, pll_seen);
    end
    wr(`ADR_CHAN, 14'h0ABC);
    chk("chan", 16'h0ABC, {4'h0, chan});
    chk("pll", 16'h037F, pll_seen);
    wr(`ADR_TEST, 14'h002B);
    chk("test", 16'h002B, {10'h000, dtest, atest});
    wr(2'h3, 14'h003F);
    chk("test", 16'h002B, {10'h000, dtest, atest});
    chk("chan", 16'h0ABC, {4'h0, chan});
    chk("pll", 16'h037F, pll_seen);
    wr(`ADR_TEST, 14'h0000);
    host.send(4'hF, 1'b1, {14'h0123, `ADR_CHAN});
    host.cyc(2);
    chk("chan", 16'h0123, {4'h0, chan});
    host.idle_noise(6);
    chk("chan", 16'h0123, {4'h0, chan});
    // the load cannot show idle shifting, so the shifter itself is looked at
    chk("word", {14'h0123, `ADR_CHAN}, uut.word);
    // all mode pin combinations
    for (int i = 0; i < 4; i++) begin
      host.set_pins(i[1], i[0], 1'b0);
      chk("mode", {13'h0000, ~i[1], i[1] & i[0], i[1] & ~i[0]},
          {13'h0000, m_sb, m_rx, m_tx});
    end
    wr(`ADR_PLL, 14'h0000);
    host.set_pins(1'b1, 1'b0, 1'b0);
    chk("tx", 16'h0007, {13'h0000, pa_en, rf_on, mod_on});
    host.set_pins(1'b1, 1'b0, 1'b1);
    chk("tx", 16'h0007, {13'h0000, pa_en, rf_on, mod_on});
    wr(`ADR_PLL, 14'h0150);
    chk("tx", 16'h0000, {13'h0000, pa_en, rf_on, mod_on});
    host.set_pins(1'b1, 1'b0, 1'b0);
    chk("tx", 16'h0000, {13'h0000, pa_en, rf_on, mod_on});
    host.set_pins(1'b1, 1'b1, 1'b0);
    host.set_pins(1'b1, 1'b0, 1'b0);
    chk("tx", 16'h0006, {13'h0000, pa_en, rf_on, mod_on});
    // power bit reaches the pin only at the receive select fall
    wr(`ADR_PLL, 14'h0020);
    chk("pin_oe", 16'h0001, {15'h0000, pin_oe});
    host.set_pins(1'b1, 1'b1, 1'b0);
    host.set_pins(1'b1, 1'b0, 1'b0);
    chk("pin_oe", 16'h0000, {15'h0000, pin_oe});
    chk("pin", 16'h0001, {15'h0000, pin_lvl});
    wr(`ADR_PLL, 14'h0004);
    host.set_pins(1'b1, 1'b1, 1'b0);
    host.set_pins(1'b1, 1'b0, 1'b0);
    chk("pin_oe", 16'h0000, {15'h0000, pin_oe});
    wr(`ADR_PLL, 14'h0000);
    chk("pin_oe", 16'h0001, {15'h0000, pin_oe});
    // reset in mid-run must clear a register that holds data
    rst = 1'b1;
    host.cyc(20);
    rst = 1'b0;
    host.cyc(8);
    chk("chan", 16'h0000, {4'h0, chan});
    chk("mode", 16'h0001, {13'h0000, m_sb, m_rx, m_tx});
    close_out();
  end

  // whole run is near 2100 cycles; allow about ten times that
  initial begin
    #2000000;
    err_count++;
    close_out();
  end
endmodule // tb_top

// File: three_wire_config_regs.sv
// three-wire write-only configuration registers and mode control
// How it works
// - sixteen-bit words, MSB first, address last
// - shift data on clock rise while enable low
// - enable high: clock and data ignored
// - enable rising edge decodes address and loads
// - longer frame: last sixteen bits used
// - three registers; 00 PLL, 01 channel
// - no read path for registers
// - PLL register field layout, bits 0-9
// - channel divide word in bits 11-0
// - analog test low, digital test above
// - all registers zero after reset
// - chip enable low means standby
// - active with receive select high: receive
// - active with receive select low: transmit
// - bit 2 picks analog pin function
// - power bit 0 grounds pin, 1 floats
// - power bit applied at receive select fall
// - RF mode: on throughout transmit or follows PA
// - carrier test bit: FSK or plain carrier
// - low supply latch drops PA enable
// - RSSI clip disable passed to analog core
`timescale 1ns/1ps
`include "cfg_regs.svh"
module three_wire_config_regs (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic SER_EN_N,
  input wire logic SER_DATA,
  input wire logic SER_CLK,
  input wire logic CHIP_ENABLE_IN,
  input wire logic RECEIVE_SELECT_IN,
  input wire logic ANALOG_SUPPLY_LOW,
  input wire logic ANALOG_PIN_I,
  output logic CHARGE_PUMP_POLARITY,
  output logic REF_DIVIDE_LOW,
  output logic REF_DIVIDE_HIGH,
  output logic ANALOG_PIN_SELECT,
  output logic CARRIER_ONLY_TEST,
  output logic POWER_CONTROL_LEVEL,
  output logic RF_OUTPUT_MODE,
  output logic LOW_VOLTAGE_LOCKOUT_EN,
  output logic RSSI_CLIP_DISABLE,
  output logic [11:0] CHANNEL_DIVIDE_WORD,
  output logic [2:0] ANALOG_TEST_SELECT,
  output logic [2:0] DIGITAL_TEST_SELECT,
  output logic MODE_STANDBY_OUT,
  output logic MODE_RECEIVE_OUT,
  output logic MODE_TRANSMIT_OUT,
  output logic PA_ENABLE_OUT,
  output logic RF_OUTPUT_ON,
  output logic MODULATION_ON,
  output logic ANALOG_PIN_O,
  output logic ANALOG_PIN_OE
);

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  logic [`SYNC_W-1:0] pins_s;
  logic [`SYNC_W-1:0] pins_raw;

  assign pins_raw[`S_EN_N] = SER_EN_N;
  assign pins_raw[`S_SCLK] = SER_CLK;
  assign pins_raw[`S_SDATA] = SER_DATA;
  assign pins_raw[`S_CHIP] = CHIP_ENABLE_IN;
  assign pins_raw[`S_RX] = RECEIVE_SELECT_IN;
  assign pins_raw[`S_LOWV] = ANALOG_SUPPLY_LOW;

  // clock and data share one delay so the sampled bit stays aligned
  pin_sync u_sync (
    .clk(CORE_CLK),
    .rst(RST),
    .d(pins_raw),
    .q(pins_s)
  );

  wire en_n_s = pins_s[`S_EN_N];
  wire sclk_s = pins_s[`S_SCLK];
  wire sdata_s = pins_s[`S_SDATA];
  wire chip_s = pins_s[`S_CHIP];
  wire rx_s = pins_s[`S_RX];
  wire lowv_s = pins_s[`S_LOWV];

  // ----------------------------------------------------------------
  // serial shifter
  // ----------------------------------------------------------------
  logic [`WORD_W-1:0] word;
  logic load;

  serial_shifter u_shift (
    .clk(CORE_CLK),
    .rst(RST),
    .sclk_s(sclk_s),
    .sdata_s(sdata_s),
    .en_n_s(en_n_s),
    .word(word),
    .load(load)
  );

  // data leads, address trails in the shifted word
  wire [`DATA_W-1:0] load_data = word[`DATA_MSB:`DATA_LSB];
  wire [1:0] load_addr = word[`ADDR_MSB:`ADDR_LSB];

  // ----------------------------------------------------------------
  // address decode and register bank
  // ----------------------------------------------------------------
  function automatic logic addr_selects(input logic [1:0] addr, input int idx);
    logic hit;
    hit = 1'h0;
    case (addr)
      `ADR_PLL: hit = (idx == `IDX_PLL);
      `ADR_CHAN: hit = (idx == `IDX_CHAN);
      `ADR_TEST: hit = (idx == `IDX_TEST);
      default: hit = 1'h0;
    endcase
    return hit;
  endfunction

  // write-only: nothing here drives a read path
  cfg_pkg::cfg_word_t cfg_ff [`NUM_REGS];

  genvar gi;
  generate
    for (gi = 0; gi < `NUM_REGS; gi++) begin : g_reg
      wire sel = load & addr_selects(load_addr, gi);
      always_ff @(posedge CORE_CLK) begin
        if (RST) begin
          cfg_ff[gi] <= `REG_RESET;
        end else if (sel) begin
          cfg_ff[gi] <= load_data;
        end
      end
    end
  endgenerate

  wire [`DATA_W-1:0] pll_w = cfg_ff[`IDX_PLL];
  wire [`DATA_W-1:0] chan_w = cfg_ff[`IDX_CHAN];
  wire [`DATA_W-1:0] test_w = cfg_ff[`IDX_TEST];

  // ----------------------------------------------------------------
  // static field outputs
  // ----------------------------------------------------------------
  assign CHARGE_PUMP_POLARITY = pll_w[`CP_POL_BIT];
  assign REF_DIVIDE_LOW = pll_w[`REF_LO_BIT];
  assign ANALOG_PIN_SELECT = pll_w[`APIN_SEL_BIT];
  assign REF_DIVIDE_HIGH = pll_w[`REF_HI_BIT];
  assign CARRIER_ONLY_TEST = pll_w[`CARRIER_BIT];
  assign POWER_CONTROL_LEVEL = pll_w[`PWR_CTL_BIT];
  assign RF_OUTPUT_MODE = pll_w[`RF_MODE_BIT];
  assign LOW_VOLTAGE_LOCKOUT_EN = pll_w[`LOW_VOLTAGE_LOCKOUT_EN_BIT];
  assign RSSI_CLIP_DISABLE = pll_w[`RSSI_CLIP_BIT];
  assign CHANNEL_DIVIDE_WORD = chan_w[`CHAN_MSB:`CHAN_LSB];
  assign ANALOG_TEST_SELECT = test_w[`ATEST_MSB:`ATEST_LSB];
  assign DIGITAL_TEST_SELECT = test_w[`DTEST_MSB:`DTEST_LSB];

  // ----------------------------------------------------------------
  // operating mode
  // ----------------------------------------------------------------
  cfg_pkg::op_mode_t mode_ff;
  cfg_pkg::op_mode_t nxt_mode;

  // serial port keeps working in standby; chip enable reaches only the mode logic
  assign nxt_mode = !chip_s ? cfg_pkg::MODE_STANDBY :
                    rx_s ? cfg_pkg::MODE_RECEIVE :
                    cfg_pkg::MODE_TRANSMIT;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      mode_ff <= cfg_pkg::MODE_STANDBY;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  logic is_rx;
  logic is_tx;
  always_comb begin
    is_rx = 1'h0;
    is_tx = 1'h0;
    case (mode_ff)
      cfg_pkg::MODE_STANDBY: begin
        is_rx = 1'h0;
      end
      cfg_pkg::MODE_RECEIVE: begin
        is_rx = 1'h1;
      end
      cfg_pkg::MODE_TRANSMIT: begin
        is_tx = 1'h1;
      end
      default: begin
        is_rx = 1'h0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // receive select edges, lockout latch, power control pin
  // ----------------------------------------------------------------
  logic rx_prev_ff;
  logic lockout_ff;
  logic pc_level_ff;
  wire rx_rise = rx_s & ~rx_prev_ff;
  wire rx_fall = ~rx_s & rx_prev_ff;

  // a low-supply event in the clearing cycle still sets the latch
  wire lock_set = pll_w[`LOW_VOLTAGE_LOCKOUT_EN_BIT] & lowv_s;
  wire nxt_lockout = lock_set | (lockout_ff & ~rx_rise);
  // power level reaches the pin only at a receive select fall
  wire nxt_pc_level = rx_fall ? pll_w[`PWR_CTL_BIT] : pc_level_ff;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      rx_prev_ff <= 1'h0;
      lockout_ff <= 1'h0;
      pc_level_ff <= 1'h0;
    end else begin
      rx_prev_ff <= rx_s;
      lockout_ff <= nxt_lockout;
      pc_level_ff <= nxt_pc_level;
    end
  end

  // ----------------------------------------------------------------
  // registered control outputs
  // ----------------------------------------------------------------
  wire pa_on = is_tx & ~lockout_ff;
  wire rf_on = is_tx & (pll_w[`RF_MODE_BIT] ? pa_on : 1'h1);
  wire mod_on = is_tx & ~pll_w[`CARRIER_BIT];
  // analog test selects other than zero take the pin away from power control
  wire pc_func = ~pll_w[`APIN_SEL_BIT] & (test_w[`ATEST_MSB:`ATEST_LSB] == `ATEST_OFF);
  wire pc_pull = pc_func & ~pc_level_ff;

  logic stby_ff;
  logic rxo_ff;
  logic txo_ff;
  logic pa_ff;
  logic rf_ff;
  logic mod_ff;
  logic pin_oe_ff;
  logic pin_o_ff;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      stby_ff <= 1'h1;
      rxo_ff <= 1'h0;
      txo_ff <= 1'h0;
      pa_ff <= 1'h0;
      rf_ff <= 1'h0;
      mod_ff <= 1'h0;
      pin_oe_ff <= 1'h0;
      pin_o_ff <= 1'h0;
    end else begin
      stby_ff <= ~(is_rx | is_tx);
      rxo_ff <= is_rx;
      txo_ff <= is_tx;
      pa_ff <= pa_on;
      rf_ff <= rf_on;
      mod_ff <= mod_on;
      pin_oe_ff <= pc_pull;
      pin_o_ff <= 1'h0;
    end
  end

  assign MODE_STANDBY_OUT = stby_ff;
  assign MODE_RECEIVE_OUT = rxo_ff;
  assign MODE_TRANSMIT_OUT = txo_ff;
  assign PA_ENABLE_OUT = pa_ff;
  assign RF_OUTPUT_ON = rf_ff;
  assign MODULATION_ON = mod_ff;
  assign ANALOG_PIN_O = pin_o_ff;
  assign ANALOG_PIN_OE = pin_oe_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  sequence s_load_to(logic [1:0] a);
    load && load_addr == a;
  endsequence

  sequence s_sclk_rise_framed;
    sclk_s && !$past(sclk_s) && !en_n_s;
  endsequence

  property p_load_pll;
    s_load_to(`ADR_PLL) |=> pll_w == $past(load_data) && chan_w == $past(chan_w);
  endproperty
  a_load_pll: assert property (p_load_pll) else $error("pll load wrong");

  property p_load_chan;
    s_load_to(`ADR_CHAN) |=> chan_w == $past(load_data) && test_w == $past(test_w);
  endproperty
  a_load_chan: assert property (p_load_chan) else $error("channel load wrong");

  property p_load_test;
    s_load_to(`ADR_TEST) |=> test_w == $past(load_data) && pll_w == $past(pll_w);
  endproperty
  a_load_test: assert property (p_load_test) else $error("test load wrong");

  property p_ignore_11;
    s_load_to(2'h3) |=> $stable(pll_w) && $stable(chan_w) && $stable(test_w);
  endproperty
  a_ignore_11: assert property (p_ignore_11) else $error("code 11 changed a register");

  property p_no_load_hold;
    !load |=> $stable(pll_w) && $stable(chan_w) && $stable(test_w);
  endproperty
  a_no_load_hold: assert property (p_no_load_hold) else $error("register moved");

  property p_shift_in;
    s_sclk_rise_framed |=> word == {$past(word[`WORD_W-2:0]), $past(sdata_s)};
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("bit not shifted");

  property p_idle_ignored;
    en_n_s && $past(en_n_s) |=> $stable(word);
  endproperty
  a_idle_ignored: assert property (p_idle_ignored) else $error("shift while idle");

  property p_mode_map;
    ##1 1'h1 |-> ##1 (stby_ff == !$past(chip_s, 2))
      && (rxo_ff == ($past(chip_s, 2) && $past(rx_s, 2)))
      && (txo_ff == ($past(chip_s, 2) && !$past(rx_s, 2)));
  endproperty
  a_mode_map: assert property (p_mode_map) else $error("mode outputs wrong");

  property p_lockout_drops_pa;
    lock_set |=> ##1 !pa_ff;
  endproperty
  a_lockout_drops_pa: assert property (p_lockout_drops_pa) else $error("pa not dropped");

  property p_lockout_clear;
    lockout_ff && rx_rise && !lock_set |=> !lockout_ff;
  endproperty
  a_lockout_clear: assert property (p_lockout_clear) else $error("latch not cleared");

  property p_pc_only_on_fall;
    !rx_fall |=> pc_level_ff == $past(pc_level_ff);
  endproperty
  a_pc_only_on_fall: assert property (p_pc_only_on_fall) else $error("power level early");

  property p_pin_pull;
    pc_func && !pc_level_ff |=> ANALOG_PIN_OE && !ANALOG_PIN_O;
  endproperty
  a_pin_pull: assert property (p_pin_pull) else $error("pin not pulled");

  property p_rf_follow;
    is_tx && pll_w[`RF_MODE_BIT] |=> RF_OUTPUT_ON == PA_ENABLE_OUT;
  endproperty
  a_rf_follow: assert property (p_rf_follow) else $error("rf not following pa");

  property p_carrier;
    is_tx && pll_w[`CARRIER_BIT] |=> !MODULATION_ON;
  endproperty
  a_carrier: assert property (p_carrier) else $error("carrier still modulated");

  property p_reset_zero;
    @(posedge CORE_CLK) disable iff (1'h0) RST |=> pll_w == `REG_RESET && chan_w == `REG_RESET
      && test_w == `REG_RESET;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("reset value wrong");

endmodule // three_wire_config_regs
